// ### core/cpu_regs_pkg.sv
// Shared constants and carrier types for the CPU register set
package cpu_regs_pkg;

  // ----------------------------------------------------------------
  // Widths
  // ----------------------------------------------------------------
  localparam int unsigned WORD_W     = 32;
  localparam int unsigned CTRL8_W    = 8;
  localparam int unsigned ACC_W      = 64;
  localparam int unsigned NUM_GP     = 8;
  localparam int unsigned GP_IDX_W   = 3;
  localparam int unsigned SEL16_W    = 4;

  // ----------------------------------------------------------------
  // Register indices and condition_flags bit positions
  // ----------------------------------------------------------------
  localparam logic [2:0] SP_IDX     = 3'h7;
  localparam int unsigned CF_MASK   = 7;
  localparam int unsigned CF_UI     = 6;
  localparam int unsigned CF_HALF   = 5;
  localparam int unsigned CF_USER   = 4;
  localparam int unsigned CF_NEG    = 3;
  localparam int unsigned CF_ZERO   = 2;
  localparam int unsigned CF_OVF    = 1;
  localparam int unsigned CF_CARRY  = 0;

  // Half-carry tap positions per operand size
  localparam int unsigned HC_BYTE   = 3;
  localparam int unsigned HC_WORD   = 11;
  localparam int unsigned HC_LONG   = 27;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [7:0]  CF_RESET    = 8'h80;
  localparam logic [7:0]  EXT_RESET   = 8'h87;
  localparam logic [31:0] WORD_RESET  = 32'h0000_0000;
  localparam logic [63:0] ACC_RESET   = 64'h0000_0000_0000_0000;
  localparam logic [31:0] FETCH_ALIGN = 32'hFFFF_FFFE;

  // ----------------------------------------------------------------
  // Enumerations
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    SZ_BYTE = 2'b00,
    SZ_WORD = 2'b01,
    SZ_LONG = 2'b10
  } op_size_t;

  typedef enum logic [2:0] {
    CF_NONE  = 3'b000,
    CF_LOAD  = 3'b001,
    CF_AND   = 3'b010,
    CF_OR    = 3'b011,
    CF_XOR   = 3'b100,
    CF_ARITH = 3'b101,
    CF_LOGIC = 3'b110
  } cf_op_t;

  typedef enum logic [1:0] {
    AR_ADD = 2'b00,
    AR_SUB = 2'b01,
    AR_NEG = 2'b10
  } arith_t;

  typedef enum logic [2:0] {
    CT_EXT  = 3'b000,
    CT_VBR  = 3'b001,
    CT_SBR  = 3'b010,
    CT_MACH = 3'b011,
    CT_MACL = 3'b100
  } ctrl_sel_t;

  // ----------------------------------------------------------------
  // Carriers
  // ----------------------------------------------------------------
  // sel: for bytes, {idx, high}; for words, {idx, upper}
  typedef struct packed {
    logic              en;
    op_size_t          size;
    logic [3:0]        sel;
    logic [31:0]       data;
  } gp_wr_t;

  typedef struct packed {
    logic              en;
    arith_t            kind;
    op_size_t          size;
    logic              carry_in;
    logic              use_extend;
    logic [31:0]       a;
    logic [31:0]       b;
  } alu_req_t;

  typedef struct packed {
    logic [31:0]       result;
    logic              neg;
    logic              zero;
    logic              ovf;
    logic              carry;
    logic              half;
  } alu_res_t;

endpackage

// ### core/gp_reg_bank.sv
// Eight general registers with 32/16/8-bit views
`timescale 1ns/1ps
module gp_reg_bank (
  input  wire logic                  ref_clk_i,
  input  wire logic                  nrst_i,
  input  wire cpu_regs_pkg::gp_wr_t  wr_i,
  input  wire logic                  sp_wr_i,
  input  wire logic [31:0]           sp_data_i,
  input  wire logic [3:0]            rd_sel_i,
  input  wire cpu_regs_pkg::op_size_t rd_size_i,
  output logic [31:0]                rd_data_o,
  output logic [31:0]                sp_o
);

  logic [31:0] wide_gp_regs [8];

  function automatic logic [31:0] view_read(input logic [31:0] r,
                                            input cpu_regs_pkg::op_size_t sz,
                                            input logic hi);
    unique case (sz)
      cpu_regs_pkg::SZ_BYTE: return {24'h000000, hi ? r[15:8] : r[7:0]};
      cpu_regs_pkg::SZ_WORD: return {16'h0000, hi ? r[31:16] : r[15:0]};
      default:               return r;
    endcase
  endfunction

  // Lane merge keeps the untouched bits of the wide register
  function automatic logic [31:0] view_write(input logic [31:0] r,
                                             input cpu_regs_pkg::op_size_t sz,
                                             input logic hi,
                                             input logic [31:0] d);
    logic [31:0] v;
    v = r;
    unique case (sz)
      cpu_regs_pkg::SZ_BYTE: begin
        if (hi) v[15:8] = d[7:0]; else v[7:0] = d[7:0];
      end
      cpu_regs_pkg::SZ_WORD: begin
        if (hi) v[31:16] = d[15:0]; else v[15:0] = d[15:0];
      end
      default: v = d;
    endcase
    return v;
  endfunction

  // --------------------------------------------------------------
  // Storage
  // --------------------------------------------------------------
  // Stack pointer update loses to an explicit write of the same register
  always_ff @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      for (int i = 0; i < 8; i++) wide_gp_regs[i] <= cpu_regs_pkg::WORD_RESET;
    end else begin
      if (sp_wr_i) wide_gp_regs[cpu_regs_pkg::SP_IDX] <= sp_data_i;
      if (wr_i.en)
        wide_gp_regs[wr_i.sel[3:1]] <= view_write(wide_gp_regs[wr_i.sel[3:1]],
                                                  wr_i.size, wr_i.sel[0], wr_i.data);
    end
  end

  always_ff @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      rd_data_o <= cpu_regs_pkg::WORD_RESET;
      sp_o      <= cpu_regs_pkg::WORD_RESET;
    end else begin
      rd_data_o <= view_read(wide_gp_regs[rd_sel_i[3:1]], rd_size_i, rd_sel_i[0]);
      sp_o      <= wide_gp_regs[cpu_regs_pkg::SP_IDX];
    end
  end

endmodule

// ### core/flag_alu.sv
// Arithmetic flag generator for add, subtract, compare and negate
`timescale 1ns/1ps
module flag_alu (
  input  wire cpu_regs_pkg::alu_req_t req_i,
  output cpu_regs_pkg::alu_res_t      res_o
);

  function automatic int unsigned msb_of(input cpu_regs_pkg::op_size_t sz);
    unique case (sz)
      cpu_regs_pkg::SZ_BYTE: return 7;
      cpu_regs_pkg::SZ_WORD: return 15;
      default:               return 31;
    endcase
  endfunction

  always_comb begin
    logic [32:0] ext_a;
    logic [32:0] ext_b;
    logic [32:0] sum;
    logic [31:0] carries;
    logic [31:0] mask;
    logic        cin;
    logic        sub;
    int unsigned m;
    int unsigned h;
    mask = 32'hFFFF_FFFF;
    h = cpu_regs_pkg::HC_LONG;
    m = msb_of(req_i.size);
    unique case (req_i.size)
      cpu_regs_pkg::SZ_BYTE: begin mask = 32'h0000_00FF; h = cpu_regs_pkg::HC_BYTE; end
      cpu_regs_pkg::SZ_WORD: begin mask = 32'h0000_FFFF; h = cpu_regs_pkg::HC_WORD; end
      default:               begin mask = 32'hFFFF_FFFF; h = cpu_regs_pkg::HC_LONG; end
    endcase
    sub   = (req_i.kind != cpu_regs_pkg::AR_ADD);
    // Negate is 0 - b; subtraction done as a + ~b + 1 so carry is inverted borrow
    ext_a = (req_i.kind == cpu_regs_pkg::AR_NEG) ? 33'h0 : {1'b0, req_i.a & mask};
    ext_b = {1'b0, (sub ? ~req_i.b : req_i.b) & mask};
    cin   = req_i.use_extend ? (sub ? ~req_i.carry_in : req_i.carry_in) : sub;
    sum   = ext_a + ext_b + {32'h0000_0000, cin};
    carries = ext_a[31:0] ^ ext_b[31:0] ^ sum[31:0];
    res_o.result = sum[31:0] & mask;
    res_o.neg    = sum[m];
    res_o.zero   = ((sum[31:0] & mask) == 32'h0000_0000);
    res_o.ovf    = (ext_a[m] == ext_b[m]) && (sum[m] != ext_a[m]);
    res_o.carry  = (((ext_a[m] & ext_b[m]) | ((ext_a[m] | ext_b[m]) & carries[m])) ^ sub);
    // Carry into bit h+1 marks carry or borrow out of bit h
    res_o.half   = carries[h + 1] ^ sub;
  end

endmodule

// ### core/cpu_register_set.sv
// Programmer-visible register set: general registers, PC and control registers
//
// Operation
// - Provide PC, control, condition, bases, accumulator registers
// - Eight interchangeable 32-bit general registers
// - Data access as 32, 16 or 8 bits
// - Upper and lower halves: sixteen 16-bit registers
// - Lower half splits into high and low bytes
// - Index view chosen by operand size
// - Eighth register doubles as stack pointer
// - PC is 32 bits, next instruction address
// - Fetch address forces PC bit zero low
// - Condition register load, store, AND, OR, XOR
// - Branch conditions use N, Z, V, C
// - Mask bit resets to one, blocks interrupts
// - Exception entry forces mask bit to one
// - Bits 6 and 4 are user bits
// - Byte half-carry at bit 3
// - Word half-carry at bit 11
// - Longword half-carry at bit 27
// - Negative flag takes result sign
// - Zero flag set for zero result; extended arithmetic keeps the prior Z on a zero result
// - Overflow flag set on arithmetic overflow
// - Carry flag: carry, borrow, shift-out, bit accumulator
`timescale 1ns/1ps
module cpu_register_set (
  input  wire logic                    ref_clk_i,
  input  wire logic                    nrst_i,
  // General register access
  input  wire cpu_regs_pkg::gp_wr_t    gp_wr_i,
  input  wire logic [3:0]              gp_rd_sel_i,
  input  wire cpu_regs_pkg::op_size_t  gp_rd_size_i,
  output logic [31:0]                  gp_rd_data_o,
  // Index register view
  input  wire logic [2:0]              idx_sel_i,
  input  wire cpu_regs_pkg::op_size_t  idx_size_i,
  output logic [31:0]                  idx_value_o,
  // Stack pointer implicit use
  input  wire logic                    sp_wr_i,
  input  wire logic [31:0]             sp_data_i,
  output logic [31:0]                  stack_pointer_o,
  // Program counter
  input  wire logic                    pc_load_i,
  input  wire logic [31:0]             pc_data_i,
  input  wire logic                    pc_step_i,
  input  wire logic [2:0]              pc_step_bytes_i,
  output logic [31:0]                  pc_o,
  output logic [31:0]                  fetch_addr_o,
  // Condition flags
  input  wire cpu_regs_pkg::cf_op_t    cf_op_i,
  input  wire logic [7:0]              cf_imm_i,
  input  wire cpu_regs_pkg::alu_req_t  alu_req_i,
  input  wire logic [7:0]              logic_flags_i,
  input  wire logic                    exc_entry_i,
  input  wire logic                    irq_pending_i,
  output logic [7:0]                   condition_flags_o,
  output logic [31:0]                  alu_result_o,
  output logic                         irq_accept_o,
  output logic                         irq_accept_ui_o,
  output logic [3:0]                   branch_flags_o,
  // Other control registers
  input  wire logic                    ctrl_wr_i,
  input  wire cpu_regs_pkg::ctrl_sel_t ctrl_sel_i,
  input  wire logic [31:0]             ctrl_data_i,
  input  wire logic                    acc_wr_i,
  input  wire logic [63:0]             acc_data_i,
  output logic [7:0]                   extended_control_o,
  output logic [31:0]                  vector_base_o,
  output logic [31:0]                  short_address_base_o,
  output logic [63:0]                  multiply_accumulator_o
);

  // ----------------------------------------------------------------
  // General registers
  // ----------------------------------------------------------------
  logic [31:0] bank_rd;
  logic [31:0] bank_sp;
  logic [31:0] idx_raw;
  logic [31:0] wide_shadow [8];

  gp_reg_bank u_bank (
    .ref_clk_i (ref_clk_i),
    .nrst_i    (nrst_i),
    .wr_i      (gp_wr_i),
    .sp_wr_i   (sp_wr_i),
    .sp_data_i (sp_data_i),
    .rd_sel_i  (gp_rd_sel_i),
    .rd_size_i (gp_rd_size_i),
    .rd_data_o (bank_rd),
    .sp_o      (bank_sp)
  );

  assign gp_rd_data_o    = bank_rd;
  assign stack_pointer_o = bank_sp;

  // Shadow copy feeds the index path so it can read in parallel with the data port
  always_ff @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      for (int i = 0; i < 8; i++) wide_shadow[i] <= cpu_regs_pkg::WORD_RESET;
    end else begin
      if (sp_wr_i) wide_shadow[cpu_regs_pkg::SP_IDX] <= sp_data_i;
      if (gp_wr_i.en) begin
        unique case (gp_wr_i.size)
          cpu_regs_pkg::SZ_BYTE: begin
            if (gp_wr_i.sel[0]) wide_shadow[gp_wr_i.sel[3:1]][15:8] <= gp_wr_i.data[7:0];
            else wide_shadow[gp_wr_i.sel[3:1]][7:0] <= gp_wr_i.data[7:0];
          end
          cpu_regs_pkg::SZ_WORD: begin
            if (gp_wr_i.sel[0]) wide_shadow[gp_wr_i.sel[3:1]][31:16] <= gp_wr_i.data[15:0];
            else wide_shadow[gp_wr_i.sel[3:1]][15:0] <= gp_wr_i.data[15:0];
          end
          default: wide_shadow[gp_wr_i.sel[3:1]] <= gp_wr_i.data;
        endcase
      end
    end
  end

  // Index uses only the low byte, lower half, or full register
  always_comb begin
    idx_raw = wide_shadow[idx_sel_i];
    unique case (idx_size_i)
      cpu_regs_pkg::SZ_BYTE: idx_raw = {24'h000000, wide_shadow[idx_sel_i][7:0]};
      cpu_regs_pkg::SZ_WORD: idx_raw = {16'h0000, wide_shadow[idx_sel_i][15:0]};
      default:               idx_raw = wide_shadow[idx_sel_i];
    endcase
  end

  always_ff @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) idx_value_o <= cpu_regs_pkg::WORD_RESET;
    else idx_value_o <= idx_raw;
  end

  // ----------------------------------------------------------------
  // Program counter
  // ----------------------------------------------------------------
  logic [31:0] pc;
  logic [31:0] next_pc;

  always_comb begin
    next_pc = pc;
    if (pc_load_i) next_pc = pc_data_i;
    else if (pc_step_i) next_pc = pc + {29'h0, pc_step_bytes_i};
  end

  always_ff @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      pc           <= cpu_regs_pkg::WORD_RESET;
      pc_o         <= cpu_regs_pkg::WORD_RESET;
      fetch_addr_o <= cpu_regs_pkg::WORD_RESET;
    end else begin
      pc           <= next_pc;
      pc_o         <= next_pc;
      fetch_addr_o <= next_pc & cpu_regs_pkg::FETCH_ALIGN;
    end
  end

  // ----------------------------------------------------------------
  // Condition flags
  // ----------------------------------------------------------------
  cpu_regs_pkg::alu_res_t alu_res;
  logic [7:0]             flags;
  logic [7:0]             next_flags;

  flag_alu u_alu (
    .req_i (alu_req_i),
    .res_o (alu_res)
  );

  always_comb begin
    next_flags = flags;
    unique case (cf_op_i)
      cpu_regs_pkg::CF_LOAD: next_flags = cf_imm_i;
      cpu_regs_pkg::CF_AND:  next_flags = flags & cf_imm_i;
      cpu_regs_pkg::CF_OR:   next_flags = flags | cf_imm_i;
      cpu_regs_pkg::CF_XOR:  next_flags = flags ^ cf_imm_i;
      cpu_regs_pkg::CF_ARITH: begin
        next_flags[cpu_regs_pkg::CF_HALF]  = alu_res.half;
        next_flags[cpu_regs_pkg::CF_NEG]   = alu_res.neg;
        // Extended forms keep Z when the result is zero so multiword compares chain
        next_flags[cpu_regs_pkg::CF_ZERO]  = alu_req_i.use_extend ?
                                             (alu_res.zero & flags[cpu_regs_pkg::CF_ZERO]) :
                                             alu_res.zero;
        next_flags[cpu_regs_pkg::CF_OVF]   = alu_res.ovf;
        next_flags[cpu_regs_pkg::CF_CARRY] = alu_res.carry;
      end
      // Shift, rotate and bit operations hand their N, Z, V, C in directly
      cpu_regs_pkg::CF_LOGIC: next_flags[3:0] = logic_flags_i[3:0];
      default: next_flags = flags;
    endcase
    // User bits only move through the control-register operations above
    if (exc_entry_i) next_flags[cpu_regs_pkg::CF_MASK] = 1'b1;
  end

  // User bits reset to a defined zero; only the mask has a documented value
  always_ff @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) flags <= cpu_regs_pkg::CF_RESET;
    else flags <= next_flags;
  end

  always_ff @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      condition_flags_o <= cpu_regs_pkg::CF_RESET;
      branch_flags_o    <= cpu_regs_pkg::CF_RESET[3:0];
      irq_accept_o      <= 1'b0;
      irq_accept_ui_o   <= 1'b0;
      alu_result_o      <= cpu_regs_pkg::WORD_RESET;
    end else begin
      condition_flags_o <= next_flags;
      branch_flags_o    <= next_flags[3:0];
      irq_accept_o      <= irq_pending_i & ~next_flags[cpu_regs_pkg::CF_MASK];
      // Variant for systems that use bit 6 as a second mask level
      irq_accept_ui_o   <= irq_pending_i & ~next_flags[cpu_regs_pkg::CF_MASK]
                           & ~next_flags[cpu_regs_pkg::CF_UI];
      alu_result_o      <= alu_req_i.en ? alu_res.result : alu_result_o;
    end
  end

  // ----------------------------------------------------------------
  // Other control registers (layouts owned elsewhere)
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      extended_control_o     <= cpu_regs_pkg::EXT_RESET;
      vector_base_o          <= cpu_regs_pkg::WORD_RESET;
      short_address_base_o   <= cpu_regs_pkg::WORD_RESET;
      multiply_accumulator_o <= cpu_regs_pkg::ACC_RESET;
    end else begin
      if (acc_wr_i) multiply_accumulator_o <= acc_data_i;
      if (ctrl_wr_i) begin
        unique case (ctrl_sel_i)
          cpu_regs_pkg::CT_EXT:  extended_control_o <= ctrl_data_i[7:0];
          cpu_regs_pkg::CT_VBR:  vector_base_o <= ctrl_data_i;
          cpu_regs_pkg::CT_SBR:  short_address_base_o <= ctrl_data_i;
          cpu_regs_pkg::CT_MACH: multiply_accumulator_o[63:32] <= ctrl_data_i;
          cpu_regs_pkg::CT_MACL: multiply_accumulator_o[31:0] <= ctrl_data_i;
          default: ;
        endcase
      end
    end
  end

endmodule

// ### dv/cpu_regs_chk.sv
// Port-level assertions for the CPU register set
`timescale 1ns/1ps
module cpu_regs_chk (
  input wire logic                   ref_clk_i,
  input wire logic                   nrst_i,
  input wire logic                   exc_entry_i,
  input wire logic                   irq_pending_i,
  input wire logic                   sp_wr_i,
  input wire logic [31:0]            sp_data_i,
  input wire cpu_regs_pkg::gp_wr_t   gp_wr_i,
  input wire cpu_regs_pkg::cf_op_t   cf_op_i,
  input wire logic [7:0]             cf_imm_i,
  input wire cpu_regs_pkg::alu_req_t alu_req_i,
  input wire logic [7:0]             condition_flags_o,
  input wire logic [31:0]            alu_result_o,
  input wire logic                   irq_accept_o,
  input wire logic [3:0]             branch_flags_o,
  input wire logic [31:0]            stack_pointer_o,
  input wire logic [31:0]            pc_o,
  input wire logic [31:0]            fetch_addr_o
);
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (!nrst_i);
  logic arith;
  logic hc;
  // Exception entry overrides the mask bit of any flag write, so those cycles are left out
  assign arith = cf_op_i == cpu_regs_pkg::CF_ARITH && alu_req_i.en && !exc_entry_i;
  assign hc = ({1'b0, alu_req_i.a[3:0]} + {1'b0, alu_req_i.b[3:0]}) > 5'h0F;
  sequence sp_set;
    sp_wr_i && !gp_wr_i.en;
  endsequence
  sequence sp_shown;
    ##2 stack_pointer_o == $past(sp_data_i, 2);
  endsequence
  AST_FETCH_ALIGN: assert property (fetch_addr_o == {pc_o[31:1], 1'b0})
    else $error("fetch address does not track the program counter");
  AST_BRANCH_FLAGS: assert property (branch_flags_o == condition_flags_o[3:0])
    else $error("branch flags differ from the condition flags");
  AST_EXC_MASK: assert property (exc_entry_i |=> condition_flags_o[7])
    else $error("mask bit not set by exception entry");
  AST_CF_LOAD: assert property (
    cf_op_i == cpu_regs_pkg::CF_LOAD && !exc_entry_i |=> condition_flags_o == $past(cf_imm_i))
    else $error("flag load lost");
  AST_IRQ_MASK: assert property (
    1'b1 |=> irq_accept_o == ($past(irq_pending_i) && !condition_flags_o[7]))
    else $error("interrupt accepted against the mask");
  AST_SP_FOLLOW: assert property (sp_set |-> sp_shown)
    else $error("stack pointer copy wrong");
  AST_HALF_BYTE: assert property (
    arith && alu_req_i.kind == cpu_regs_pkg::AR_ADD && alu_req_i.size == cpu_regs_pkg::SZ_BYTE
    && !alu_req_i.use_extend && !alu_req_i.carry_in |=> condition_flags_o[5] == $past(hc))
    else $error("byte half carry wrong");
  AST_NEG_LONG: assert property (
    arith && alu_req_i.size == cpu_regs_pkg::SZ_LONG |=> condition_flags_o[3] == alu_result_o[31])
    else $error("negative flag differs from result sign");
endmodule
bind cpu_register_set cpu_regs_chk u_chk (.ref_clk_i, .nrst_i, .exc_entry_i, .irq_pending_i,
  .sp_wr_i, .sp_data_i, .gp_wr_i, .cf_op_i, .cf_imm_i, .alu_req_i, .condition_flags_o,
  .alu_result_o, .irq_accept_o, .branch_flags_o, .stack_pointer_o, .pc_o, .fetch_addr_o);

// ### dv/dp_model.sv
// Datapath model issuing random general register writes and reads with a shadow copy
`timescale 1ns/1ps
module dp_model (
  input  wire logic              ref_clk_i,
  input  wire logic              run_i,
  output cpu_regs_pkg::gp_wr_t   wr_o,
  output logic [3:0]             sel_o,
  output cpu_regs_pkg::op_size_t size_o,
  output logic [31:0]            exp_o,
  output logic [31:0]            exp_idx_o,
  output logic                   chk_o
);
  logic [31:0] shadow [8] = '{default: 32'h0};
  logic [31:0] r;
  logic [31:0] d;
  logic [3:0]  s;
  logic [1:0]  phase = 2'h0;
  int          seed = 20;
  cpu_regs_pkg::op_size_t z;
  initial begin
    wr_o = '0;
    sel_o = 4'h0;
    size_o = cpu_regs_pkg::SZ_BYTE;
    chk_o = 1'b0;
  end
  // Write, read and check take turns so a read never races a write
  always @(posedge ref_clk_i) begin
    d = $random(seed);
    s = d[3:0];
    z = cpu_regs_pkg::op_size_t'(2'(d[31:28] % 4'h3));
    d = $random(seed);
    r = shadow[s[3:1]];
    wr_o <= '{run_i && phase == 2'h0, z, s, d};
    chk_o <= run_i && phase == 2'h2;
    if (run_i) phase <= phase == 2'h2 ? 2'h0 : phase + 2'h1;
    if (run_i && phase == 2'h0) begin
      if (z == cpu_regs_pkg::SZ_BYTE) begin
        if (s[0]) r[15:8] = d[7:0]; else r[7:0] = d[7:0];
      end else if (z == cpu_regs_pkg::SZ_WORD) begin
        if (s[0]) r[31:16] = d[15:0]; else r[15:0] = d[15:0];
      end else begin
        r = d;
      end
      shadow[s[3:1]] <= r;
    end
    if (run_i && phase == 2'h1) begin
      sel_o <= s;
      size_o <= z;
      exp_o <= z == cpu_regs_pkg::SZ_BYTE ? {24'h0, s[0] ? r[15:8] : r[7:0]} :
               z == cpu_regs_pkg::SZ_WORD ? {16'h0, s[0] ? r[31:16] : r[15:0]} : r;
      exp_idx_o <= z == cpu_regs_pkg::SZ_BYTE ? {24'h0, r[7:0]} :
                   z == cpu_regs_pkg::SZ_WORD ? {16'h0, r[15:0]} : r;
    end
  end
endmodule

// ### dv/cpu_register_set_with_flags_tb.sv
// Self-checking bench for the CPU register set
`timescale 1ns/1ps
module cpu_register_set_with_flags_tb;
  logic ref_clk_i = 1'b0;
  logic nrst_i = 1'b0;
  cpu_regs_pkg::gp_wr_t gp_wr_i;
  cpu_regs_pkg::op_size_t gp_rd_size_i, idx_size_i;
  cpu_regs_pkg::cf_op_t cf_op_i = cpu_regs_pkg::CF_NONE;
  cpu_regs_pkg::ctrl_sel_t ctrl_sel_i = cpu_regs_pkg::CT_VBR;
  cpu_regs_pkg::alu_req_t alu_req_i = '0, alu_next = '0;
  logic [3:0] gp_rd_sel_i, branch_flags_o;
  logic [2:0] idx_sel_i;
  logic [2:0] pc_step_bytes_i = 3'h2;
  logic [7:0] cf_imm_i = 8'h00, logic_flags_i = 8'h00, condition_flags_o, extended_control_o, e;
  logic [31:0] sp_data_i = '0, pc_data_i = '0, ctrl_data_i = '0, exp_rd, exp_idx, d, m;
  logic [31:0] gp_rd_data_o, idx_value_o, stack_pointer_o, pc_o, fetch_addr_o, alu_result_o;
  logic [31:0] vector_base_o, short_address_base_o;
  logic [63:0] acc_data_i = '0, multiply_accumulator_o;
  logic sp_wr_i = 1'b0, pc_load_i = 1'b0, pc_step_i = 1'b0, exc_entry_i = 1'b0;
  logic irq_pending_i = 1'b0, ctrl_wr_i = 1'b0, acc_wr_i = 1'b0, run = 1'b0;
  logic irq_accept_o, irq_accept_ui_o, chk;
  logic [36:0] r;
  int seed = 20, err_total = 0, tests_run = 0;
  assign idx_sel_i = gp_rd_sel_i[3:1];
  assign idx_size_i = gp_rd_size_i;
  always #20 ref_clk_i = ~ref_clk_i;
  dp_model partner (.ref_clk_i(ref_clk_i), .run_i(run), .wr_o(gp_wr_i), .sel_o(gp_rd_sel_i),
    .size_o(gp_rd_size_i), .exp_o(exp_rd), .exp_idx_o(exp_idx), .chk_o(chk));
  cpu_register_set dut (.*);
  task automatic cmp(input logic [63:0] got, input logic [63:0] exp);
    tests_run++;
    if (got !== exp) begin
      err_total++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  task automatic cf(input cpu_regs_pkg::cf_op_t op, input logic [7:0] v, input logic x);
    @(posedge ref_clk_i);
    cf_op_i <= op;
    cf_imm_i <= v;
    exc_entry_i <= x;
    alu_req_i <= alu_next;
    logic_flags_i <= v;
    @(posedge ref_clk_i);
    cf_op_i <= cpu_regs_pkg::CF_NONE;
    exc_entry_i <= 1'b0;
    @(negedge ref_clk_i);
  endtask
  // Result view and flags {res, H, N, Z, V, C} for an add or subtract of width w
  function automatic logic [36:0] ref_alu(input int w, input logic sub, input logic [31:0] a,
                                          input logic [31:0] b);
    logic [32:0] s;
    logic [32:0] h;
    logic [31:0] k;
    logic [31:0] q;
    k = 32'hFFFF_FFFF >> (32 - w);
    a = a & k;
    b = b & k;
    q = k >> 4;
    s = sub ? {1'b0, a} - {1'b0, b} : {1'b0, a} + {1'b0, b};
    h = sub ? {1'b0, a & q} - {1'b0, b & q} : {1'b0, a & q} + {1'b0, b & q};
    return {s[31:0] & k, h[w - 4], s[w - 1], (s[31:0] & k) == 32'h0,
            ((a[w - 1] ^ b[w - 1]) == sub) && (s[w - 1] != a[w - 1]), s[w]};
  endfunction
  always @(negedge ref_clk_i) begin
    if (chk) begin
      cmp(gp_rd_data_o, exp_rd);
      cmp(idx_value_o, exp_idx);
    end
  end
  initial begin
    #100000;
    err_total++;
    end_of_test();
  end
  initial begin
    repeat (20) @(posedge ref_clk_i);
    cmp(condition_flags_o, 8'h80);
    cmp(extended_control_o, 8'h87);
    nrst_i <= 1'b1;
    irq_pending_i <= 1'b1;
    cf(cpu_regs_pkg::CF_NONE, 8'h00, 1'b0);
    cmp(irq_accept_o, 1'b0);
    e = 8'h80;
    for (int i = 1; i < 5; i++) begin
      d = $random(seed);
      cf(cpu_regs_pkg::cf_op_t'(3'(i)), d[7:0], 1'b0);
      e = i == 1 ? d[7:0] : i == 2 ? e & d[7:0] : i == 3 ? e | d[7:0] : e ^ d[7:0];
      cmp(condition_flags_o, e);
      cmp(branch_flags_o, e[3:0]);
    end
    cf(cpu_regs_pkg::CF_LOAD, 8'h00, 1'b0);
    cf(cpu_regs_pkg::CF_NONE, 8'h00, 1'b0);
    cmp({irq_accept_o, irq_accept_ui_o}, 2'h3);
    cf(cpu_regs_pkg::CF_LOAD, 8'h40, 1'b0);
    cf(cpu_regs_pkg::CF_NONE, 8'h00, 1'b0);
    cmp({irq_accept_o, irq_accept_ui_o}, 2'h2);
    cf(cpu_regs_pkg::CF_LOAD, 8'h10, 1'b1);
    cmp(condition_flags_o, 8'h90);
    $display("test flag ops done");
    e = 8'h90;
    for (int i = 0; i < 60; i++) begin
      d = i == 0 ? 32'h0000_000F : $random(seed);
      m = i == 0 ? 32'h0000_0001 : $random(seed);
      alu_next = '{1'b1, cpu_regs_pkg::arith_t'(i % 4 == 3 ? 2'h2 : {1'b0, i[0]}),
                   cpu_regs_pkg::op_size_t'(2'(i % 3)), 1'b0, 1'b0, d, m};
      r = ref_alu(i % 3 == 0 ? 8 : i % 3 == 1 ? 16 : 32, i[0], i % 4 == 3 ? 32'h0 : d, m);
      cf(cpu_regs_pkg::CF_ARITH, 8'h00, 1'b0);
      e = {e[7:6], r[4], e[4], r[3:0]};
      cmp(condition_flags_o, e);
      cmp(alu_result_o & (i % 3 == 0 ? 32'hFF : i % 3 == 1 ? 32'hFFFF : '1), r[36:5]);
    end
    d = $random(seed);
    cf(cpu_regs_pkg::CF_LOGIC, d[7:0], 1'b0);
    cmp(branch_flags_o, d[3:0]);
    $display("test arithmetic flags done");
    @(posedge ref_clk_i);
    run <= 1'b1;
    repeat (180) @(posedge ref_clk_i);
    run <= 1'b0;
    $display("test register views done");
    d = $random(seed);
    @(posedge ref_clk_i);
    sp_wr_i <= 1'b1;
    sp_data_i <= d;
    @(posedge ref_clk_i);
    sp_wr_i <= 1'b0;
    repeat (2) @(negedge ref_clk_i);
    cmp(stack_pointer_o, d);
    d = $random(seed) | 32'h1;
    @(posedge ref_clk_i);
    pc_load_i <= 1'b1;
    pc_data_i <= d;
    @(posedge ref_clk_i);
    pc_load_i <= 1'b0;
    pc_step_i <= 1'b1;
    @(negedge ref_clk_i);
    cmp(pc_o, d);
    cmp(fetch_addr_o, d & 32'hFFFF_FFFE);
    @(posedge ref_clk_i);
    pc_step_i <= 1'b0;
    @(negedge ref_clk_i);
    cmp(pc_o, d + 32'h2);
    for (int i = 0; i < 5; i++) begin
      d = $random(seed);
      @(posedge ref_clk_i);
      ctrl_wr_i <= 1'b1;
      ctrl_sel_i <= cpu_regs_pkg::ctrl_sel_t'(3'(i));
      ctrl_data_i <= d;
      acc_wr_i <= i == 0;
      acc_data_i <= {~d, d};
      @(posedge ref_clk_i);
      ctrl_wr_i <= 1'b0;
      acc_wr_i <= 1'b0;
      @(negedge ref_clk_i);
      if (i == 0) cmp(multiply_accumulator_o, {~d, d});
      m = i == 1 ? vector_base_o : i == 2 ? short_address_base_o : multiply_accumulator_o[31:0];
      m = i == 3 ? multiply_accumulator_o[63:32] : i == 0 ? {24'h0, extended_control_o} : m;
      cmp(m, i == 0 ? {24'h0, d[7:0]} : d);
    end
    $display("test pointer and control registers done");
    end_of_test();
  end
endmodule
